/* hdl/ext_bus_pins.v */
/*
 External pin sampling, bus request/grant and memory strobe sequencing.
 Inputs are synchronous to clk_i except bus_request_n_i, which is
 synchronised here. Tristate wires are resolved outside from enables.
*/
// How it works
// - Interrupt and flag inputs are registered on the clock edge after they settle.
// - Bus request is registered in the cycle it is seen stable.
// - Bus grant goes low two cycles after request is recognised, the cycle after controls float.
// - Bus request may be asynchronous; it is synchronised inside.
// - Selects and strobes are driven again only after grant returns high.
// - Address and select are presented a cycle before read strobe falls.
// - Address and select stay stable until after read strobe rises.
// - Write data is driven only once write strobe is low.
// - Write data is valid before write strobe rises.
// - Write data is held one cycle after write strobe rises.
// - Address and selects stay unchanged until after write strobe rises, except the boot select, which is dropped as write strobe falls.
// - Flag output updates only on a clock edge, held in a register.
`include "ext_bus_regs.vh"

module ext_bus_pins (
   input  wire                  clk_i,
   input  wire                  rst_b_i,
   input  wire [`IRQ_W-1:0]     external_interrupt_line_n_i,
   input  wire                  flag_in_pin_i,
   input  wire                  flag_out_value_i,
   output reg  [`IRQ_W-1:0]     irq_sampled_n_o,
   output reg                   flag_in_sampled_o,
   output reg                   flag_out_pin_o,
   input  wire                  bus_request_n_i,
   output reg                   bus_grant_n_o,
   input  wire                  acc_req_i,
   input  wire                  acc_write_i,
   input  wire [1:0]            acc_space_i,
   input  wire [`ADDR_W-1:0]    acc_addr_i,
   input  wire [`DATA_W-1:0]    acc_wdata_i,
   input  wire [`WAIT_W-1:0]    acc_waits_i,
   output wire                  acc_ready_o,
   output reg                   acc_done_o,
   output reg  [`DATA_W-1:0]    acc_rdata_o,
   output reg  [`ADDR_W-1:0]    addr_o,
   output reg                   data_space_select_n_o,
   output reg                   program_space_select_n_o,
   output reg                   boot_space_select_n_o,
   output reg                   rd_n_o,
   output reg                   wr_n_o,
   output reg                   ctrl_oe_o,
   input  wire [`DATA_W-1:0]    data_i,
   output reg  [`DATA_W-1:0]    data_o,
   output reg                   data_oe_o
);

   localparam [2:0] PH_IDLE   = `PH_IDLE;
   localparam [2:0] PH_SETUP  = `PH_SETUP;
   localparam [2:0] PH_STROBE = `PH_STROBE;
   localparam [2:0] PH_WAIT   = `PH_WAIT;
   localparam [2:0] PH_HOLD   = `PH_HOLD;
   localparam [2:0] PH_GRANT  = `PH_GRANT;

   reg  [2:0]          phase;
   reg  [2:0]          next_phase;
   reg                 req_sync1;
   reg                 req_seen;
   reg                 is_write;
   reg  [1:0]          space;
   reg  [`WAIT_W-1:0]  wait_left;
   reg  [`DATA_W-1:0]  wdata;

   // Space code to active-low select vector {boot, program, data}
   function [2:0] space_sel_n;
      input [1:0] sp;
      begin
         case (sp)
            2'h0:    space_sel_n = 3'b110;
            2'h1:    space_sel_n = 3'b101;
            2'h2:    space_sel_n = 3'b011;
            default: space_sel_n = 3'b111;
         endcase
      end
   endfunction

   // Accept new access only when idle and bus not requested
   assign acc_ready_o = (phase == PH_IDLE) && req_seen;

   // Pin sampling and flag output registers
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_sampled_n_o   <= {`IRQ_W{1'b1}};
         flag_in_sampled_o <= 1'b0;
         flag_out_pin_o    <= 1'b0;
      end else begin
         irq_sampled_n_o   <= external_interrupt_line_n_i;
         flag_in_sampled_o <= flag_in_pin_i;
         flag_out_pin_o    <= flag_out_value_i;
      end
   end

   // Bus request synchroniser, two stages
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         req_sync1 <= 1'b1;
         req_seen  <= 1'b1;
      end else begin
         req_sync1 <= bus_request_n_i;
         req_seen  <= req_sync1;
      end
   end

   // Next access phase
   always @* begin
      next_phase = phase;
      case (phase)
         PH_IDLE: begin
            if (!req_seen)
               next_phase = PH_GRANT;
            else if (acc_req_i)
               next_phase = PH_SETUP;
         end
         PH_SETUP:  next_phase = PH_STROBE;
         PH_STROBE: next_phase = (wait_left != 0) ? PH_WAIT : PH_HOLD;
         PH_WAIT:   next_phase = (wait_left == 1) ? PH_HOLD : PH_WAIT;
         PH_HOLD:   next_phase = PH_IDLE;
         PH_GRANT:  next_phase = req_seen ? PH_IDLE : PH_GRANT;
         default:   next_phase = PH_IDLE;
      endcase
   end

   // Access sequencer and pin drivers
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase                    <= PH_IDLE;
         is_write                 <= 1'b0;
         space                    <= 2'h3;
         wait_left                <= {`WAIT_W{1'b0}};
         wdata                    <= `DATA_RST;
         addr_o                   <= `ADDR_RST;
         data_space_select_n_o    <= 1'b1;
         program_space_select_n_o <= 1'b1;
         boot_space_select_n_o    <= 1'b1;
         rd_n_o                   <= 1'b1;
         wr_n_o                   <= 1'b1;
         ctrl_oe_o                <= 1'b1;
         bus_grant_n_o            <= 1'b1;
         data_o                   <= `DATA_RST;
         data_oe_o                <= 1'b0;
         acc_done_o               <= 1'b0;
         acc_rdata_o              <= `DATA_RST;
      end else begin
         phase      <= next_phase;
         acc_done_o <= 1'b0;
         case (phase)
            PH_IDLE: begin
               if (!req_seen) begin
                  ctrl_oe_o <= 1'b0;
               end else if (acc_req_i) begin
                  // Address and select go out a cycle before the strobe
                  is_write  <= acc_write_i;
                  space     <= acc_space_i;
                  wait_left <= acc_waits_i;
                  wdata     <= acc_wdata_i;
                  addr_o    <= acc_addr_i;
                  {boot_space_select_n_o, program_space_select_n_o,
                   data_space_select_n_o} <= space_sel_n(acc_space_i);
               end
            end
            PH_SETUP: begin
               if (is_write) begin
                  wr_n_o <= 1'b0;
                  // Data enabled with the strobe fall, a full cycle before it rises
                  data_o    <= wdata;
                  data_oe_o <= 1'b1;
                  // Boot space is read-only; drop its select as the write strobe falls
                  if (space == 2'h2)
                     boot_space_select_n_o <= 1'b1;
               end else begin
                  rd_n_o <= 1'b0;
               end
            end
            PH_STROBE: begin
               if (wait_left == 0) begin
                  if (!is_write)
                     acc_rdata_o <= data_i;
                  rd_n_o <= 1'b1;
                  wr_n_o <= 1'b1;
               end
            end
            PH_WAIT: begin
               wait_left <= wait_left - 1'b1;
               if (wait_left == 1) begin
                  if (!is_write)
                     acc_rdata_o <= data_i;
                  rd_n_o <= 1'b1;
                  wr_n_o <= 1'b1;
               end
            end
            PH_HOLD: begin
               // Address, selects and data held through this cycle
               data_oe_o <= 1'b0;
               {boot_space_select_n_o, program_space_select_n_o,
                data_space_select_n_o} <= 3'b111;
               acc_done_o <= 1'b1;
            end
            PH_GRANT: begin
               if (req_seen) begin
                  bus_grant_n_o <= 1'b1;
               end else begin
                  bus_grant_n_o <= 1'b0;
               end
            end
            default: begin
               rd_n_o <= 1'b1;
            end
         endcase
         // Regain the bus only once grant is back high
         if (phase == PH_IDLE && req_seen && bus_grant_n_o)
            ctrl_oe_o <= 1'b1;
      end
   end

endmodule

/* include/ext_bus_regs.vh */
/*
 Timing and field constants for the external bus and pin sampling block.
 Assumes a 125 MHz core clock; included by the design file by bare name.
*/
`ifndef EXT_BUS_REGS_VH
`define EXT_BUS_REGS_VH

// Widths of the external buses
`define ADDR_W          14
`define DATA_W          16
`define IRQ_W           3
`define WAIT_W          3

// Clock period and minimum edge pulse width in picoseconds
`define CLK_PERIOD_PS   8000
`define EDGE_PULSE_PS   10000

// Access phase codes
`define PH_IDLE         3'h0
`define PH_SETUP        3'h1
`define PH_STROBE       3'h2
`define PH_WAIT         3'h3
`define PH_HOLD         3'h4
`define PH_GRANT        3'h5

// Reset values
`define ADDR_RST        14'h0000
`define DATA_RST        16'h0000

`endif

/* dv/ext_bus_pins_properties.sv */
/*
 Port timing checker for ext_bus_pins.
 Bound from the bench top file; sees only the block's ports.
*/
`include "ext_bus_regs.vh"
module ext_bus_pins_properties (
   input wire               clk_i,
   input wire               rst_b_i,
   input wire [`IRQ_W-1:0]  external_interrupt_line_n_i,
   input wire [`IRQ_W-1:0]  irq_sampled_n_o,
   input wire               flag_out_value_i,
   input wire               flag_out_pin_o,
   input wire               bus_request_n_i,
   input wire               bus_grant_n_o,
   input wire               acc_ready_o,
   input wire               ctrl_oe_o,
   input wire               rd_n_o,
   input wire               wr_n_o,
   input wire               data_oe_o,
   input wire [`ADDR_W-1:0] addr_o,
   input wire               data_space_select_n_o,
   input wire               program_space_select_n_o,
   input wire               boot_space_select_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire [2:0] sel = {data_space_select_n_o, program_space_select_n_o, boot_space_select_n_o};
   // Grant stays off three edges, then arrives within one to three more
   sequence grant_wait;
      bus_grant_n_o [*3] ##[1:3] !bus_grant_n_o;
   endsequence
   // Write data held one edge past strobe
   sequence data_tail;
      data_oe_o ##1 !data_oe_o;
   endsequence
   irq_sample_a: assert property ($past(rst_b_i) |-> irq_sampled_n_o == $past(external_interrupt_line_n_i))
      else $error("interrupt sample wrong");
   flag_out_a: assert property ($past(rst_b_i) |-> flag_out_pin_o == $past(flag_out_value_i))
      else $error("flag output wrong");
   grant_delay_a: assert property ($fell(bus_request_n_i) && bus_grant_n_o && acc_ready_o |-> grant_wait)
      else $error("grant timing wrong");
   float_first_a: assert property ($fell(bus_grant_n_o) |-> !ctrl_oe_o && $past(ctrl_oe_o) == 1'b0)
      else $error("grant before float");
   drive_back_a: assert property ($rose(ctrl_oe_o) |-> $past(bus_grant_n_o))
      else $error("driven while granted");
   read_setup_a: assert property ($fell(rd_n_o) |-> $stable(addr_o) && $past(sel) != 3'h7)
      else $error("read setup missing");
   read_hold_a: assert property (!rd_n_o |=> $stable(addr_o) && $stable(sel))
      else $error("read hold broken");
   write_hold_a: assert property (!wr_n_o |=> $stable(addr_o) && $stable(sel[2:1]))
      else $error("write hold broken");
   data_late_a: assert property ($rose(data_oe_o) |-> !wr_n_o)
      else $error("data driven early");
   data_tail_a: assert property ($rose(wr_n_o) |-> data_tail)
      else $error("write data tail wrong");
endmodule

/* dv/ext_mem_model.sv */
/*
 External memory partner: answers reads, captures written words.
 Assumes active-low strobes and the data enable of ext_bus_pins.
*/
`include "ext_bus_regs.vh"
module ext_mem_model (
   input wire                clk_i,
   input wire                rd_n_o,
   input wire                wr_n_o,
   input wire                data_oe_o,
   input wire [`ADDR_W-1:0]  addr_o,
   input wire [`DATA_W-1:0]  data_o,
   output logic [`DATA_W-1:0] data_i,
   output logic [`DATA_W-1:0] wr_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_q;
   // Word follows address; inverted while strobe is off
   assign data_i = ({addr_o, 2'h1} ^ 16'ha5c3) ^ {16{rd_n_o}};
   // Capture one edge after strobe rise, while still driven
   always @(posedge clk_i) begin
      wr_q <= wr_n_o;
      if (!wr_q && wr_n_o && data_oe_o) wr_word <= data_o;
   end
endmodule

/* dv/test_ext_bus_pins.sv */
/*
 Self-checking bench for ext_bus_pins with a memory partner.
 Bench plays the outside bus master; inputs change 1 ns after edges.
*/
`include "ext_bus_regs.vh"
module test_ext_bus_pins;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_b_i = 0, flag_in_pin_i = 0, flag_out_value_i = 0;
   logic bus_request_n_i = 1, acc_req_i = 0, acc_write_i = 0;
   logic flag_in_sampled_o, flag_out_pin_o, bus_grant_n_o, acc_ready_o, acc_done_o, rd_n_o;
   logic data_space_select_n_o, program_space_select_n_o, boot_space_select_n_o;
   logic wr_n_o, ctrl_oe_o, data_oe_o;
   logic [`IRQ_W-1:0] external_interrupt_line_n_i = 3'h7, irq_sampled_n_o;
   logic [1:0] acc_space_i = 2'h0;
   logic [`ADDR_W-1:0] acc_addr_i = 14'h0000, addr_o;
   logic [`DATA_W-1:0] acc_wdata_i = 16'h0000, acc_rdata_o, data_i, data_o, wr_word;
   logic [`WAIT_W-1:0] acc_waits_i = 3'h0;
   int bad_count = 0, tests_run = 0;
   ext_bus_pins DUT (.*);
   ext_mem_model mem (.*);
   initial forever #4 clk_i = ~clk_i;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task wrap_up;
      $display("Mismatches %0d in %0d checks", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task step;
      @(posedge clk_i);
      #1;
   endtask
   // Pins sampled one edge later; each pattern held two cycles
   task t_pins;
      for (int i = 0; i < 8; i++) begin
         external_interrupt_line_n_i = 3'(i);
         flag_in_pin_i = i[0];
         flag_out_value_i = i[1];
         step;
         chk({irq_sampled_n_o, flag_in_sampled_o, flag_out_pin_o}, {i[2:0], i[0], i[1]});
         step;
         chk({irq_sampled_n_o, flag_in_sampled_o, flag_out_pin_o}, {i[2:0], i[0], i[1]});
      end
   endtask
   // One access; optional bus request raised right after it is taken
   task t_access(input logic wr, input logic [1:0] sp, input logic [2:0] w, input logic br);
      int n, lo;
      n = 0;
      lo = 0;
      acc_write_i = wr;
      acc_space_i = sp;
      acc_addr_i = {sp, w, 9'h0a5};
      acc_wdata_i = {acc_addr_i, 2'h2};
      acc_waits_i = w;
      acc_req_i = 1;
      step;
      acc_req_i = 0;
      bus_request_n_i = !br;
      while (acc_done_o !== 1'b1 && n < 20) begin
         step;
         n++;
         if (!rd_n_o || !wr_n_o) lo++;
         if (n == 1)
            chk({data_space_select_n_o, program_space_select_n_o, boot_space_select_n_o},
                (wr && sp == 2'h2) ? 3'h7 : 3'h7 ^ (3'h4 >> sp));
      end
      chk(n, 3 + w);
      chk(lo, 1 + w);
      if (n >= 20) wrap_up;
      if (!wr) chk(acc_rdata_o, {acc_addr_i, 2'h1} ^ 16'ha5c3);
      else begin
         step;
         chk(wr_word, acc_wdata_i);
      end
   endtask
   // Hand the bus out and take it back
   task t_grant;
      int n;
      n = 0;
      bus_request_n_i = 0;
      while (bus_grant_n_o !== 1'b0 && n < 12) begin
         step;
         n++;
      end
      chk({ctrl_oe_o, acc_ready_o, n < 12}, 3'h1);
      bus_request_n_i = 1;
      while (bus_grant_n_o !== 1'b1 && n < 24) begin
         step;
         n++;
      end
      step;
      chk({ctrl_oe_o, n < 24}, 2'h3);
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      #1 rst_b_i = 1;
      t_pins;
      for (int k = 0; k < 6; k++) t_access(k[0], 2'(k / 2), 3'(k), 1'b0);
      t_access(1'b0, 2'h1, 3'h7, 1'b0);
      t_access(1'b1, 2'h0, 3'h0, 1'b1);
      t_grant;
      t_grant;
      wrap_up;
   end
endmodule
bind ext_bus_pins ext_bus_pins_properties u_props (.*);
